//--- dv/iopw_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module iopw_assertions (
  input wire clk_i, rst_n_i, stop_deep_i, stop_light_i, stopped_o, core_run_o,
  input wire [7:0] port_a_dir_i, port_a_pull_high_i, port_a_out_o, port_a_oe_n_o,
  input wire [7:0] port_a_pull_high_on_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_req; core_run_o && (stop_light_i || stop_deep_i); endsequence
  sequence s_held; stopped_o && !core_run_o; endsequence
  a_stop_entry: assert property (s_req |=> s_held) else $error("no stop");
  a_run_excl: assert property (!(stopped_o && core_run_o)) else $error("both");
  a_resume_clean: assert property ($rose(core_run_o) |-> $fell(stopped_o)) else $error("rs");
  a_wake_delay: assert property ($fell(core_run_o) |=> !core_run_o [*2]) else $error("early");
  a_drive_en: assert property ($past(rst_n_i) |->
    (port_a_oe_n_o | 8'h20) == ($past(~port_a_dir_i) | 8'h20)) else $error("oe");
  a_pull_high: assert property ($past(rst_n_i) |->
    port_a_pull_high_on_o == $past(port_a_pull_high_i & ~port_a_dir_i)) else $error("ph");
  a_out_no_pull: assert property ((~port_a_oe_n_o & port_a_pull_high_on_o) == 8'h00)
    else $error("pull");
  a_open_drain: assert property (port_a_out_o[5] == 1'b0) else $error("od");
endmodule
bind iopw_io_port_wakeup iopw_assertions i_iopw_assertions (.*);
`default_nettype wire

//--- dv/iopw_io_port_wakeup_tb.sv
`timescale 1ns/1ps
`default_nettype none
module iopw_io_port_wakeup_tb;
  logic clk_i = 0, rst_n_i = 0, slow_tick_i = 0, fast_boot_i = 0, timer_wake_i = 0;
  logic stop_deep_i = 0, stop_light_i = 0, comp_wake_i = 0;
  logic [7:0] misc_ctrl_i = '0, port_a_output_data_i = '0, port_a_dir_i = '0, ea = '0;
  // bit 0 is an interrupt pin, digital input kept on; other pins gated as analog
  logic [7:0] port_a_pull_high_i = '0, port_a_din_en_i = 8'h01, port_b_pad_i = '0;
  logic [7:0] port_b_output_data_i = 8'h08, port_b_dir_i = 8'h08, port_b_din_en_i = '0;
  logic [7:0] port_b_pull_high_i = 8'hff, port_b_pull_low_i = 8'hff;
  wire [7:0] port_a_pad_i, port_a_out_o, port_a_oe_n_o, port_a_pull_high_on_o, port_a_read_o;
  wire [7:0] port_b_out_o, port_b_oe_n_o, port_b_pull_high_on_o, port_b_pull_low_on_o;
  wire [7:0] port_b_read_o;
  wire stopped_o, core_run_o;
  int bad_count = 0, comparisons = 0, n, k = 0;
  // dir, data, pull-high, far level, pull-high on, read
  logic [47:0] rows [4] = '{48'h0000ffa5ffa5, 48'hff3cff00003c, 48'h0f5af0c3f0ca, 48'hf0a50f3c0fac};
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) #1 slow_tick_i = (k++ % 4 == 0);
  iopw_io_port_wakeup #(.WAKE_NORMAL_TICKS(10), .WAKE_FAST_TICKS(3)) i_iopw_io_port_wakeup (.*);
  iopw_pad_model i_iopw_pad_model (.clk_i, .oe_n_i(port_a_oe_n_o), .out_i(port_a_out_o),
    .ph_i(port_a_pull_high_on_o), .ext_en_i(~port_a_dir_i), .ext_i(ea), .pad_o(port_a_pad_i));
  task chk(input logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task report_and_stop;
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // stop, toggle a gated pin, then wake from source s and time it
  task go(input logic f, m, d, input int s, t);
    fast_boot_i = f;
    misc_ctrl_i = {2'h0, m, 5'h00};
    {stop_deep_i, stop_light_i} = {d, !d};
    @(posedge clk_i) #1 {stop_deep_i, stop_light_i} = 2'h0;
    repeat (3) @(posedge clk_i);
    #1 ea[1] = !ea[1];
    {timer_wake_i, comp_wake_i} = {d, d};
    repeat (20) @(posedge clk_i);
    #1 chk(core_run_o, 0);
    chk(stopped_o, 1);
    if (s == 1) timer_wake_i = 1;
    else if (s == 2) comp_wake_i = 1;
    else ea[0] = !ea[0];
    for (n = 0; n < 200 && core_run_o !== 1; n++) @(posedge clk_i) #1;
    chk(n > 4 * t - 6 && n < 4 * t + 8, 1);
    chk(stopped_o, 0);
    {timer_wake_i, comp_wake_i} = 2'h0;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    #1 chk(port_a_oe_n_o, 8'hff);
    rst_n_i = 1;
    foreach (rows[i]) begin
      {port_a_dir_i, port_a_output_data_i, port_a_pull_high_i, ea} = rows[i][47:16];
      repeat (4) @(posedge clk_i);
      #1 chk(port_a_pull_high_on_o, rows[i][15:8]);
      chk(port_a_read_o, rows[i][7:0]);
    end
    chk(port_b_pull_low_on_o, 8'h40);
    chk(port_b_out_o, 8'h08);
    chk(port_b_oe_n_o, 8'hf7);
    chk(port_b_pull_high_on_o, 8'hf7);
    chk(port_b_read_o, 8'h08);
    chk(port_a_out_o, 8'h85);
    chk(port_a_oe_n_o, 8'h2f);
    port_b_dir_i = 8'h09;
    repeat (2) @(posedge clk_i);
    #1 chk(port_b_oe_n_o, 8'hf6);
    chk(port_b_pull_high_on_o, 8'hf6);
    port_b_dir_i = 8'h08;
    {port_a_dir_i, ea} = 16'h0000;
    repeat (4) @(posedge clk_i);
    #1 go(1, 0, 0, 1, 3);
    go(0, 0, 1, 0, 10);
    go(0, 1, 0, 2, 3);
    go(0, 0, 0, 0, 10);
    report_and_stop;
  end
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire

//--- dv/iopw_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module iopw_pad_model (
  input wire logic clk_i,
  input wire logic [7:0] oe_n_i, out_i, ph_i, ext_en_i, ext_i,
  output logic [7:0] pad_o
);
  logic [7:0] last_q = 8'h00;
  // released pins without pull drift off their last level
  assign pad_o = ~oe_n_i & out_i | oe_n_i & (ext_en_i & ext_i |
    ~ext_en_i & (ph_i | ~last_q));
  always @(posedge clk_i) last_q <= pad_o;
endmodule
`default_nettype wire

//--- hdl/iopw_io_port_wakeup.v
// Overview of operation
// - an enabled input pin toggle ends either stop mode
// - timer and comparator wake only in light stop; deep stop pin only
// - normal wake waits about 3000 slow oscillator periods
// - fast wake waits about 45 slow oscillator periods
// - fast boot option forces fast wake always
// - normal boot option picks wake speed from control bit 5
// - pin wakes only when input and digital-input enable set
// - each pin configured by data, direction and pull-high bits
// - direction 0 is input; pull-high follows its enable bit
// - direction 1 drives data; driving low drops pull-high
// - driving high drops the pull-low
// - pull-low only on port b bits 3 and 6, inputs only
// - input may have both pulls; output has none
// - data read gives pad for inputs, stored bit for outputs
// - port a bit 5 and port b bit 0 are open-drain outputs
// - wake resumes after stop with state unchanged
`timescale 1ns/1ps
`default_nettype none
`include "iopw_regs.vh"
module iopw_io_port_wakeup #(
  parameter integer WAKE_NORMAL_TICKS = `IOPW_WAKE_NORMAL_TICKS,
  parameter integer WAKE_FAST_TICKS = `IOPW_WAKE_FAST_TICKS
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire slow_tick_i,
  input wire fast_boot_i,
  input wire [7:0] misc_ctrl_i,
  input wire [7:0] port_a_output_data_i,
  input wire [7:0] port_a_dir_i,
  input wire [7:0] port_a_pull_high_i,
  input wire [7:0] port_a_din_en_i,
  input wire [7:0] port_b_output_data_i,
  input wire [7:0] port_b_dir_i,
  input wire [7:0] port_b_pull_high_i,
  input wire [7:0] port_b_pull_low_i,
  input wire [7:0] port_b_din_en_i,
  input wire [7:0] port_a_pad_i,
  input wire [7:0] port_b_pad_i,
  input wire stop_deep_i,
  input wire stop_light_i,
  input wire timer_wake_i,
  input wire comp_wake_i,
  output reg [7:0] port_a_out_o,
  output reg [7:0] port_a_oe_n_o,
  output reg [7:0] port_a_pull_high_on_o,
  output reg [7:0] port_a_read_o,
  output reg [7:0] port_b_out_o,
  output reg [7:0] port_b_oe_n_o,
  output reg [7:0] port_b_pull_high_on_o,
  output reg [7:0] port_b_pull_low_on_o,
  output reg [7:0] port_b_read_o,
  output reg stopped_o,
  output reg core_run_o
);
  localparam [1:0] ST_RUN = `IOPW_ST_RUN;
  localparam [1:0] ST_STOP = `IOPW_ST_STOP;
  localparam [1:0] ST_WAKE = `IOPW_ST_WAKE;
  localparam [7:0] PB_PL_MASK = `IOPW_PB_PULL_LOW_MASK;
  localparam [7:0] PA_OD_MASK = `IOPW_PA_OPEN_DRAIN_MASK;
  localparam [7:0] PB_OD_MASK = `IOPW_PB_OPEN_DRAIN_MASK;

  function [7:0] read_mux;
    input [7:0] dir;
    input [7:0] dat;
    input [7:0] pad;
    begin
      read_mux = (dir & dat) | (~dir & pad);
    end
  endfunction

  function [7:0] wake_mask;
    input [7:0] dir;
    input [7:0] din_en;
    begin
      wake_mask = ~dir & din_en;
    end
  endfunction

  function [7:0] drive_oe_n;
    input [7:0] dir;
    input [7:0] dat;
    input [7:0] od_mask;
    begin
      drive_oe_n = ~(dir & ~(od_mask & dat));
    end
  endfunction

  function [7:0] pull_high_on;
    input [7:0] dir;
    input [7:0] ph;
    begin
      pull_high_on = ph & ~dir;
    end
  endfunction

  reg [7:0] pa_s1_reg;
  reg [7:0] pa_s2_reg;
  reg [7:0] pb_s1_reg;
  reg [7:0] pb_s2_reg;
  reg [7:0] pa_snap_reg;
  reg [7:0] pb_snap_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg light_reg;
  reg fast_reg;
  reg [11:0] cnt_reg;
  reg [11:0] cnt_next;
  reg [7:0] port_a_out_next;
  reg [7:0] port_a_oe_n_next;
  reg [7:0] port_a_pull_high_on_next;
  reg [7:0] port_a_read_next;
  reg [7:0] port_b_out_next;
  reg [7:0] port_b_oe_n_next;
  reg [7:0] port_b_pull_high_on_next;
  reg [7:0] port_b_pull_low_on_next;
  reg [7:0] port_b_read_next;
  reg stopped_next;
  reg core_run_next;
  wire [7:0] pa_wake_en;
  wire [7:0] pb_wake_en;
  wire pin_toggle;
  wire wake_event;
  wire fast_sel;

  assign pa_wake_en = wake_mask(port_a_dir_i, port_a_din_en_i);
  assign pb_wake_en = wake_mask(port_b_dir_i, port_b_din_en_i);
  assign pin_toggle = |(((pa_s2_reg ^ pa_snap_reg) & pa_wake_en) |
                        ((pb_s2_reg ^ pb_snap_reg) & pb_wake_en));
  assign wake_event = pin_toggle | (light_reg & (timer_wake_i | comp_wake_i));
  assign fast_sel = fast_boot_i | misc_ctrl_i[`IOPW_WAKE_SPEED_BIT];

  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_RUN: begin
        if (stop_deep_i | stop_light_i) begin
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        if (wake_event) begin
          state_next = ST_WAKE;
          cnt_next = 12'h000;
        end
      end
      ST_WAKE: begin
        if (slow_tick_i) begin
          cnt_next = cnt_reg + 12'h001;
          if ((fast_reg && cnt_reg == WAKE_FAST_TICKS[11:0] - 12'h001) ||
              (!fast_reg && cnt_reg == WAKE_NORMAL_TICKS[11:0] - 12'h001)) begin
            state_next = ST_RUN;
          end
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // pin drive, pull and read values for the output flops
  always @* begin
    port_a_out_next = port_a_output_data_i & ~PA_OD_MASK;
    port_a_oe_n_next = drive_oe_n(port_a_dir_i, port_a_output_data_i, PA_OD_MASK);
    port_a_pull_high_on_next = pull_high_on(port_a_dir_i, port_a_pull_high_i);
    port_a_read_next = read_mux(port_a_dir_i, port_a_output_data_i, pa_s2_reg);
    port_b_out_next = port_b_output_data_i & ~PB_OD_MASK;
    port_b_oe_n_next = drive_oe_n(port_b_dir_i, port_b_output_data_i, PB_OD_MASK);
    port_b_pull_high_on_next = pull_high_on(port_b_dir_i, port_b_pull_high_i);
    port_b_pull_low_on_next = port_b_pull_low_i & PB_PL_MASK & ~port_b_dir_i;
    port_b_read_next = read_mux(port_b_dir_i, port_b_output_data_i, pb_s2_reg);
    stopped_next = (state_next != ST_RUN);
    core_run_next = (state_next == ST_RUN);
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pa_s1_reg <= 8'h00;
      pa_s2_reg <= 8'h00;
      pb_s1_reg <= 8'h00;
      pb_s2_reg <= 8'h00;
      pa_snap_reg <= 8'h00;
      pb_snap_reg <= 8'h00;
      state_reg <= ST_RUN;
      light_reg <= 1'b0;
      fast_reg <= 1'b0;
      cnt_reg <= 12'h000;
      port_a_out_o <= 8'h00;
      port_a_oe_n_o <= 8'hff;
      port_a_pull_high_on_o <= 8'h00;
      port_a_read_o <= 8'h00;
      port_b_out_o <= 8'h00;
      port_b_oe_n_o <= 8'hff;
      port_b_pull_high_on_o <= 8'h00;
      port_b_pull_low_on_o <= 8'h00;
      port_b_read_o <= 8'h00;
      stopped_o <= 1'b0;
      core_run_o <= 1'b1;
    end else begin
      pa_s1_reg <= port_a_pad_i;
      pa_s2_reg <= pa_s1_reg;
      pb_s1_reg <= port_b_pad_i;
      pb_s2_reg <= pb_s1_reg;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (state_reg == ST_RUN && (stop_deep_i | stop_light_i)) begin
        pa_snap_reg <= pa_s2_reg;
        pb_snap_reg <= pb_s2_reg;
        light_reg <= stop_light_i & ~stop_deep_i;
        fast_reg <= fast_sel;
      end
      port_a_out_o <= port_a_out_next;
      port_a_oe_n_o <= port_a_oe_n_next;
      port_a_pull_high_on_o <= port_a_pull_high_on_next;
      port_a_read_o <= port_a_read_next;
      port_b_out_o <= port_b_out_next;
      port_b_oe_n_o <= port_b_oe_n_next;
      port_b_pull_high_on_o <= port_b_pull_high_on_next;
      port_b_pull_low_on_o <= port_b_pull_low_on_next;
      port_b_read_o <= port_b_read_next;
      stopped_o <= stopped_next;
      core_run_o <= core_run_next;
    end
  end
endmodule
`default_nettype wire

//--- hdl/iopw_regs.vh
`ifndef IOPW_REGS_VH
`define IOPW_REGS_VH
// port widths
`define IOPW_PORT_A_W 8
`define IOPW_PORT_B_W 8
// wake delays in slow oscillator periods
`define IOPW_WAKE_NORMAL_TICKS 3000
`define IOPW_WAKE_FAST_TICKS 45
// wake-speed select bit inside the misc control byte
`define IOPW_WAKE_SPEED_BIT 5
// pins with pull-low
`define IOPW_PB_PULL_LOW_MASK 8'h48
// open-drain pins
`define IOPW_PA_OPEN_DRAIN_MASK 8'h20
`define IOPW_PB_OPEN_DRAIN_MASK 8'h01
// power states
`define IOPW_ST_RUN 2'h0
`define IOPW_ST_STOP 2'h1
`define IOPW_ST_WAKE 2'h2
`endif
